// File: lbs_detector.sv
// Purpose: lin slave break detector and sync period timer
// Assumes: one 20 MHz clock, timer rates made as enable pulses
// Notes: register port answers one cycle after a read strobe
`timescale 1ns/1ns
`default_nettype none
module lbs_detector (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // interrupt line
  output logic sync_irq,
  // bus side
  lbs_if.dev bus
);
  logic s1_q, s2_q, s3_q, lvl_q, prev_q;
  logic [7:0] ctl_q;
  logic [8:0] clr_q;
  logic [7:0] edge_q;
  logic [11:0] cmp_q;
  logic [11:0] brk_q;
  logic [15:0] per_q;
  logic [3:0] fall_q, rise_q;
  logic [7:0] d5_q, d131_q;
  logic t5_q, t131_q;
  logic hit_q;
  logic st_brk_q, st_stop_q, st_err_q;
  lbs_pkg::lbs_stage_t stg_q;
  logic [31:0] rd_mux;

  // decode
  wire wr_ctl = wr && (addr == lbs_pkg::ADDR_CTRL);
  wire wr_stat = wr && (addr == lbs_pkg::ADDR_STAT);
  wire wr_edge = wr && (addr == lbs_pkg::ADDR_EDGE);
  wire wr_brk = wr && (addr == lbs_pkg::ADDR_BRK);
  wire rd_brk = rd && (addr == lbs_pkg::ADDR_BRK);
  wire srst = ctl_q[lbs_pkg::CTL_RESET];
  wire ecl = ctl_q[lbs_pkg::CTL_ECLR];
  wire en = ctl_q[lbs_pkg::CTL_EN];
  wire [3:0] stop_n = edge_q[lbs_pkg::EDGE_STOP_LSB +: 4];
  wire [3:0] start_n = edge_q[lbs_pkg::EDGE_START_LSB +: 4];

  // bus edges
  wire fall = prev_q & ~lvl_q;
  wire rise = ~prev_q & lvl_q;
  wire [3:0] fall_nx = (fall_q == 4'hf) ? fall_q : fall_q + 4'h1;
  wire [3:0] rise_nx = (rise_q == 4'hf) ? rise_q : rise_q + 4'h1;

  // break events
  // the timer still shows the count from the high time in the fall cycle
  wire match = en && !lvl_q && !fall && !hit_q && (brk_q == cmp_q);
  wire ovf = en && !lvl_q && !fall && t131_q && (brk_q == 12'hfff);
  wire start_hit = fall && (fall_nx == start_n);
  wire stop_hit = ctl_q[lbs_pkg::CTL_RISE] ? (rise && (rise_nx == stop_n))
    : (fall && (fall_nx == stop_n));
  wire stop_ev = en && (stg_q == lbs_pkg::STG_RUN) && stop_hit;

  // pin synchroniser, a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      s1_q <= bus.lin_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        lvl_q <= s3_q;
      prev_q <= lvl_q;
    end
  end

  // control with self clearing reset and edge clear bits
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_q <= 8'h0;
      clr_q <= 9'h0;
    end
    else if (wr_ctl)
    begin
      ctl_q <= wdata[7:0];
      clr_q <= (wdata[lbs_pkg::CTL_RESET] | wdata[lbs_pkg::CTL_ECLR]) ?
        9'(lbs_pkg::CLR_CYC) : 9'h0;
    end
    else if (clr_q != 9'h0)
    begin
      clr_q <= clr_q - 9'h1;
      if (clr_q == 9'h1)
      begin
        ctl_q[lbs_pkg::CTL_RESET] <= 1'b0;
        ctl_q[lbs_pkg::CTL_ECLR] <= 1'b0;
      end
    end
  end

  // setup and compare registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      edge_q <= lbs_pkg::EDGE_RST;
      cmp_q <= lbs_pkg::CMP_RST;
    end
    else if (srst)
    begin
      edge_q <= lbs_pkg::EDGE_RST;
      cmp_q <= lbs_pkg::CMP_RST;
    end
    else
    begin
      if (wr_edge)
        edge_q <= wdata[7:0];
      if (wr_brk)
        cmp_q <= wdata[11:0];
    end
  end

  // rate enables for the two timers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      d5_q <= 8'h0;
      d131_q <= 8'h0;
      t5_q <= 1'b0;
      t131_q <= 1'b0;
    end
    else
    begin
      t5_q <= (d5_q == 8'(lbs_pkg::SYNC_DIV - 1));
      d5_q <= (d5_q == 8'(lbs_pkg::SYNC_DIV - 1)) ? 8'h0 : d5_q + 8'h1;
      t131_q <= (d131_q == 8'(lbs_pkg::BRK_DIV - 1));
      d131_q <= (d131_q == 8'(lbs_pkg::BRK_DIV - 1)) ? 8'h0 : d131_q + 8'h1;
    end
  end

  // break timer and match latch
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      brk_q <= 12'h0;
      hit_q <= 1'b0;
    end
    else
    begin
      if (srst || !en || fall || rd_brk)
        brk_q <= 12'h0;
      else if (t131_q)
        brk_q <= brk_q + 12'h1;
      if (srst || !en || fall)
        hit_q <= 1'b0;
      else if (match)
        hit_q <= 1'b1;
    end
  end

  // edge counters, falling count restarted at one and rising count at zero on a break match
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fall_q <= 4'h0;
      rise_q <= 4'h0;
    end
    else if (srst || ecl || !en)
    begin
      fall_q <= 4'h0;
      rise_q <= 4'h0;
    end
    else if (match)
    begin
      fall_q <= 4'h1;
      rise_q <= 4'h0;
    end
    else
    begin
      if (fall)
        fall_q <= fall_nx;
      if (rise)
        rise_q <= rise_nx;
    end
  end

  // frame stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stg_q <= lbs_pkg::STG_IDLE;
    else if (srst || !en)
      stg_q <= lbs_pkg::STG_IDLE;
    else if (match)
      stg_q <= lbs_pkg::STG_BRK;
    else
    begin
      case (stg_q)
        lbs_pkg::STG_BRK:
          if (rise)
            stg_q <= lbs_pkg::STG_ARM;
        lbs_pkg::STG_ARM:
          if (start_hit)
            stg_q <= lbs_pkg::STG_RUN;
        lbs_pkg::STG_RUN:
          if (stop_hit)
            stg_q <= lbs_pkg::STG_DONE;
        default:
          stg_q <= stg_q;
      endcase
    end
  end

  // sync period timer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      per_q <= 16'h0;
    else if (srst || match)
      per_q <= 16'h0;
    else if (stg_q == lbs_pkg::STG_RUN && t5_q && per_q != 16'hffff)
      per_q <= per_q + 16'h1;
  end

  // sticky status, set beats a write-one clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_brk_q <= 1'b0;
      st_stop_q <= 1'b0;
      st_err_q <= 1'b0;
      sync_irq <= 1'b0;
    end
    else if (srst)
    begin
      st_brk_q <= 1'b0;
      st_stop_q <= 1'b0;
      st_err_q <= 1'b0;
      sync_irq <= 1'b0;
    end
    else
    begin
      st_brk_q <= match | (st_brk_q & ~(wr_stat & wdata[lbs_pkg::ST_BRK]));
      st_stop_q <= stop_ev | (st_stop_q & ~(wr_stat & wdata[lbs_pkg::ST_STOP]));
      st_err_q <= (ovf & hit_q) | (ovf & ~hit_q) |
        (st_err_q & ~(wr_stat & wdata[lbs_pkg::ST_ERR]));
      sync_irq <= st_brk_q | st_err_q |
        (st_stop_q & ctl_q[lbs_pkg::CTL_STOP_IE]);
    end
  end

  // read selection
  always_comb
  begin
    rd_mux = 32'h0;
    if (addr == lbs_pkg::ADDR_CTRL)
      rd_mux = {24'h0, ctl_q};
    else if (addr == lbs_pkg::ADDR_STAT)
    begin
      rd_mux[lbs_pkg::ST_BRK] = st_brk_q;
      rd_mux[lbs_pkg::ST_STOP] = st_stop_q;
      rd_mux[lbs_pkg::ST_ERR] = st_err_q;
      rd_mux[lbs_pkg::ST_BUSY] = srst;
    end
    else if (addr == lbs_pkg::ADDR_PERIOD)
      rd_mux = {16'h0, per_q};
    else if (addr == lbs_pkg::ADDR_EDGE)
      rd_mux = {24'h0, edge_q};
    else if (addr == lbs_pkg::ADDR_BRK)
      rd_mux = {20'h0, brk_q};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h0;
    else
      rdata <= rd ? rd_mux : 32'h0;
  end
endmodule
`default_nettype wire

// File: lbs_if.sv
// Purpose: single-wire lin bus joining master node and slave detector
// Assumes: open-drain bus with pull-up, master is the only driver here
// Notes: level is resolved here from the master's enable
`timescale 1ns/1ns
`default_nettype none
interface lbs_if;
  logic m_o;
  logic m_oe;
  logic lin_level;

  // pulled high unless driven low
  assign lin_level = ~(m_oe & ~m_o);

  modport dev (input lin_level);
  modport host (output m_o, output m_oe, input lin_level);
endinterface
`default_nettype wire

// File: lbs_master.sv
// Purpose: lin master node sending break, sync, protected id and data bytes
// Assumes: 20 kbps bit time, data sent lsb byte first
// Notes: open-drain, enable high drives the bus low
`timescale 1ns/1ns
`default_nettype none
module lbs_master (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user side
  input wire logic go,
  input wire logic [5:0] id,
  input wire logic [3:0] nbytes,
  input wire logic [63:0] data,
  output logic busy,
  output logic done,
  // bus side
  lbs_if.host bus
);
  lbs_pkg::lbs_hstate_t st_q;
  logic [9:0] btc_q;
  logic [3:0] nb_q;
  logic [3:0] bi_q;
  logic [3:0] last_q;
  logic [9:0] sh_q;
  logic [7:0] pid_q;
  logic [63:0] dat_q;
  logic low_q;

  wire bit_end = (btc_q == 10'(lbs_pkg::BIT_CYC - 1));
  wire p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
  wire p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
  wire [7:0] pid_w = {p1, p0, id};
  wire [3:0] n_cl = (nbytes == 4'h0) ? 4'h1 :
    ((nbytes > 4'(lbs_pkg::MAX_DATA)) ? 4'(lbs_pkg::MAX_DATA) : nbytes);
  wire [7:0] nxt_byte = (bi_q == 4'h0) ? pid_q : dat_q[7:0];
  wire last_byte = (bi_q == last_q);

  assign bus.m_o = 1'b0;
  assign bus.m_oe = low_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= lbs_pkg::HS_IDLE;
      btc_q <= 10'h0;
      nb_q <= 4'h0;
      bi_q <= 4'h0;
      last_q <= 4'h0;
      sh_q <= 10'h3ff;
      pid_q <= 8'h0;
      dat_q <= 64'h0;
      low_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      btc_q <= (st_q == lbs_pkg::HS_IDLE || bit_end) ? 10'h0 : btc_q + 10'h1;
      case (st_q)
        lbs_pkg::HS_IDLE:
        begin
          if (go)
          begin
            st_q <= lbs_pkg::HS_BRK;
            nb_q <= 4'(lbs_pkg::BRK_BITS - 1);
            pid_q <= pid_w;
            dat_q <= data;
            last_q <= n_cl + 4'h1;
            low_q <= 1'b1;
            busy <= 1'b1;
          end
        end
        lbs_pkg::HS_BRK:
        begin
          if (bit_end)
          begin
            if (nb_q == 4'h0)
            begin
              st_q <= lbs_pkg::HS_DEL;
              low_q <= 1'b0;
            end
            else
              nb_q <= nb_q - 4'h1;
          end
        end
        lbs_pkg::HS_DEL:
        begin
          if (bit_end)
          begin
            st_q <= lbs_pkg::HS_BYTE;
            sh_q <= {1'b1, lbs_pkg::SYNC_BYTE, 1'b0};
            nb_q <= 4'h9;
            bi_q <= 4'h0;
            low_q <= 1'b1;
          end
        end
        lbs_pkg::HS_BYTE:
        begin
          if (bit_end)
          begin
            if (nb_q != 4'h0)
            begin
              sh_q <= {1'b1, sh_q[9:1]};
              nb_q <= nb_q - 4'h1;
              low_q <= ~sh_q[1];
            end
            else if (last_byte)
            begin
              st_q <= lbs_pkg::HS_IDLE;
              low_q <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
            end
            else
            begin
              sh_q <= {1'b1, nxt_byte, 1'b0};
              nb_q <= 4'h9;
              bi_q <= bi_q + 4'h1;
              low_q <= 1'b1;
              if (bi_q != 4'h0)
                dat_q <= {8'h0, dat_q[63:8]};
            end
          end
        end
        default:
          st_q <= lbs_pkg::HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: lbs_pkg.sv
// Purpose: shared constants and types for the lin break and sync detector and its master node
// Assumes: 20 MHz core clock, byte addresses on a 32-bit register port
// Notes: timing counts are derived from the times and rates held here
package lbs_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'hffff0780;
  localparam logic [31:0] ADDR_STAT = 32'hffff0784;
  localparam logic [31:0] ADDR_PERIOD = 32'hffff0788;
  localparam logic [31:0] ADDR_EDGE = 32'hffff078c;
  localparam logic [31:0] ADDR_BRK = 32'hffff0790;
  // sync_edge_setup fields and reset, break compare reset
  localparam int EDGE_STOP_LSB = 4;
  localparam int EDGE_START_LSB = 0;
  localparam logic [7:0] EDGE_RST = 8'h32;
  localparam logic [11:0] CMP_RST = 12'h047;
  // sync_control bit positions
  localparam int CTL_RESET = 0;
  localparam int CTL_ECLR = 1;
  localparam int CTL_EN = 2;
  localparam int CTL_STOP_IE = 4;
  localparam int CTL_RISE = 7;
  // sync_status bit positions
  localparam int ST_BRK = 0;
  localparam int ST_STOP = 1;
  localparam int ST_ERR = 4;
  localparam int ST_BUSY = 5;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int T_CLR_NS = 15000;
  localparam int CLR_CYC = T_CLR_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int SYNC_HZ = 5_000_000;
  localparam int SYNC_DIV = CLK_HZ / SYNC_HZ;
  localparam int BRK_HZ = 131_000;
  localparam int BRK_DIV = CLK_HZ / BRK_HZ;
  // master node framing
  localparam int BAUD = 20000;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int BRK_BITS = 13;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam int MAX_DATA = 8;

  typedef enum logic [2:0]
  {
    STG_IDLE = 3'h0,
    STG_BRK = 3'h1,
    STG_ARM = 3'h3,
    STG_RUN = 3'h2,
    STG_DONE = 3'h6
  } lbs_stage_t;

  typedef enum logic [1:0]
  {
    HS_IDLE = 2'h0,
    HS_BRK = 2'h1,
    HS_DEL = 2'h3,
    HS_BYTE = 2'h2
  } lbs_hstate_t;
endpackage

// File: lbs_props.sv
// Purpose: wire and handshake properties of the lin master and detector pair
// Assumes: one 20 MHz clock, async active low reset
// Notes: sees user-side, bus, register read and interrupt signals only
`timescale 1ns/1ns
`default_nettype none
module lbs_props (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // master user side
  input wire logic go,
  input wire logic busy,
  input wire logic done,
  // bus
  input wire logic m_oe,
  input wire logic lin_level,
  // detector side
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic sync_irq
);
  // break, delimiter and ten bytes of ten bits, at 1000 clk a bit
  localparam int MAX_FRAME = 114000;
  int busy_cnt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busy_cnt <= 0;
    else if (busy)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_go_busy: assert property (go && !busy |=> busy)
    else $error("frame start not taken");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_busy_done: assert property ($fell(busy) |-> done)
    else $error("frame ended without done");
  chk_idle_free: assert property (!busy |-> !m_oe)
    else $error("bus driven while idle");
  chk_break_low: assert property ($rose(busy) |-> !lin_level [*8])
    else $error("frame does not open with low bus");
  chk_frame_len: assert property (busy_cnt <= MAX_FRAME)
    else $error("frame too long");
  chk_irq_frame: assert property ($rose(sync_irq) |-> busy)
    else $error("interrupt outside a frame");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// File: lin_break_sync_detector_tb.sv
// Purpose: self-checking bench for lin master and break sync detector
// Assumes: 20 MHz clock, 1000 clk per bit, one data byte a frame
// Notes: two frames keep the run under 100k cycles
`timescale 1ns/1ns
`default_nettype none
module lin_break_sync_detector_tb;
  logic clk;
  logic nrst;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic sync_irq;
  logic go;
  logic [5:0] id;
  logic [3:0] nbytes;
  logic [63:0] data;
  logic busy;
  logic done;
  logic [31:0] rv;
  int failures;
  int cmp_count;

  lbs_if bus_if ();
  lbs_detector lbs_detector_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sync_irq(sync_irq), .bus(bus_if.dev));
  lbs_master lbs_master_inst (.clk(clk), .nrst(nrst), .go(go), .id(id), .nbytes(nbytes),
    .data(data), .busy(busy), .done(done), .bus(bus_if.host));
  lbs_props lbs_props_inst (.clk(clk), .nrst(nrst), .go(go), .busy(busy), .done(done),
    .m_oe(bus_if.m_oe), .lin_level(bus_if.lin_level), .rd(rd), .rdata(rdata),
    .sync_irq(sync_irq));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // sends one frame and decodes the wire at every bit centre
  task automatic send_frame(input logic [5:0] fid, input logic [3:0] nb, input logic [7:0] b0);
    logic [43:0] bits;
    logic [7:0] pid;
    int n;
    pid = {~(fid[1] ^ fid[3] ^ fid[4] ^ fid[5]), fid[0] ^ fid[1] ^ fid[2] ^ fid[4], fid};
    @(posedge clk);
    id <= fid;
    nbytes <= nb;
    data <= {56'h0, b0};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (500) @(posedge clk);
    for (int k = 0; k < 44; k++)
    begin
      bits[k] = bus_if.lin_level;
      if (k < 43)
        repeat (1000) @(posedge clk);
    end
    check("break field", {18'h0, bits[13:0]}, 32'h2000);
    check("sync byte", {22'h0, bits[23:14]}, {22'h0, 1'b1, 8'h55, 1'b0});
    check("protected id", {22'h0, bits[33:24]}, {22'h0, 1'b1, pid, 1'b0});
    check("data byte", {22'h0, bits[43:34]}, {22'h0, 1'b1, b0, 1'b0});
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done", {31'h0, done}, 32'h1);
  endtask

  task automatic test_reset_values();
    reg_rd(lbs_pkg::ADDR_EDGE, rv);
    check("edge setup", rv, 32'h32);
    reg_rd(lbs_pkg::ADDR_PERIOD, rv);
    check("period", rv, 32'h0);
    reg_rd(lbs_pkg::ADDR_BRK, rv);
    check("break timer", rv, 32'h0);
    reg_rd(32'hffff07a0, rv);
    check("unmapped", rv, 32'h0);
    reg_rd(lbs_pkg::ADDR_STAT, rv);
    check("status", rv, 32'h0);
  endtask

  task automatic test_sync_frame();
    reg_wr(lbs_pkg::ADDR_EDGE, 32'h62);
    reg_wr(lbs_pkg::ADDR_CTRL, 32'h14);
    send_frame(6'h3c, 4'h0, 8'ha5);
    reg_rd(lbs_pkg::ADDR_STAT, rv);
    check("status", rv, 32'h3);
    check("irq", {31'h0, sync_irq}, 32'h1);
    reg_rd(lbs_pkg::ADDR_PERIOD, rv);
    check("period", {31'h0, rv >= 32'd1997 && rv <= 32'd2003}, 32'h1);
    reg_wr(lbs_pkg::ADDR_STAT, 32'h13);
    repeat (3) @(posedge clk);
    #1;
    check("irq clear", {31'h0, sync_irq}, 32'h0);
    reg_rd(lbs_pkg::ADDR_PERIOD, rv);
    check("period hold", {31'h0, rv >= 32'd1997 && rv <= 32'd2003}, 32'h1);
  endtask

  task automatic test_soft_reset();
    reg_wr(lbs_pkg::ADDR_CTRL, 32'h1);
    reg_rd(lbs_pkg::ADDR_STAT, rv);
    check("reset busy", rv, 32'h20);
    reg_rd(lbs_pkg::ADDR_EDGE, rv);
    check("edge default", rv, 32'h32);
    reg_rd(lbs_pkg::ADDR_PERIOD, rv);
    check("period default", rv, 32'h0);
    repeat (lbs_pkg::CLR_CYC) @(posedge clk);
    reg_rd(lbs_pkg::ADDR_CTRL, rv);
    check("self clear", rv, 32'h0);
  endtask

  // compare longer than the break: no match, so no sync timing
  task automatic test_short_break();
    reg_wr(lbs_pkg::ADDR_BRK, 32'h0a0);
    reg_wr(lbs_pkg::ADDR_CTRL, 32'h14);
    send_frame(6'h15, 4'h1, 8'h3c);
    reg_rd(lbs_pkg::ADDR_STAT, rv);
    check("no break", rv, 32'h0);
    reg_rd(lbs_pkg::ADDR_PERIOD, rv);
    check("no timing", rv, 32'h0);
    reg_rd(lbs_pkg::ADDR_BRK, rv);
    check("timer counts", {31'h0, rv != 32'h0}, 32'h1);
    reg_rd(lbs_pkg::ADDR_BRK, rv);
    check("timer read clear", {31'h0, rv <= 32'h1}, 32'h1);
  endtask

  initial
  begin
    nrst = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    go = 1'b0;
    id = 6'h0;
    nbytes = 4'h0;
    data = 64'h0;
    failures = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    test_reset_values();
    test_sync_frame();
    test_soft_reset();
    test_short_break();
    complete_run();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
